// ### design/plmr_ctrl.sv
// Purpose: loop mode sequencer, reset handling, config load and status flags
// Assumes: inputs synchronous to ref_clk; nvm read data one cycle after address
// Notes: the register port stands for the serial front end
`timescale 1ns/100ps
module plmr_ctrl #(
    parameter int CYC_PER_S = plmr_pkg::CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hard_reset_pin_n,
    input wire logic [plmr_pkg::AW-1:0] reg_addr,
    input wire logic [plmr_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [plmr_pkg::DW-1:0] reg_rdata,
    output logic nvm_rd,
    output logic nvm_we,
    output logic [plmr_pkg::NVM_AW-1:0] nvm_addr,
    output logic [plmr_pkg::DW-1:0] nvm_wdata,
    input wire logic [plmr_pkg::DW-1:0] nvm_rdata,
    input wire logic [plmr_pkg::NIN-1:0] in_clk_valid,
    input wire logic [plmr_pkg::NIN-1:0] in_off_freq,
    input wire logic loop_locked,
    output logic init_done,
    output logic out_clk_en,
    output logic loop_from_input,
    output logic [2:0] loop_mode,
    output logic [plmr_pkg::BWW-1:0] loop_bw,
    output logic [plmr_pkg::SELW-1:0] sel_input,
    output logic hist_store_en,
    output logic lock_loss_indicator,
    output logic [plmr_pkg::NIN-1:0] input_signal_absent_flag,
    output logic [plmr_pkg::NIN-1:0] input_off_frequency_flag
);
    // lowest-index valid input wins in automatic selection
    function automatic logic [plmr_pkg::SELW-1:0] pick_valid(input logic [plmr_pkg::NIN-1:0] v);
        logic [plmr_pkg::SELW-1:0] p;
        p = '0;
        for (int i = plmr_pkg::NIN - 1; i >= 0; i--)
        begin
            if (v[i])
                p = plmr_pkg::SELW'(i);
        end
        return p;
    endfunction : pick_valid

    // bandwidth codes above the top setting clamp to 4 kHz
    function automatic logic [plmr_pkg::BWW-1:0] bw_clamp(input logic [plmr_pkg::DW-1:0] d);
        return (d[plmr_pkg::BWW-1:0] > plmr_pkg::BW_MAX) ? plmr_pkg::BW_MAX : d[plmr_pkg::BWW-1:0];
    endfunction : bw_clamp

    plmr_pkg::plmr_mode_type mode_r, mode_nxt;
    logic [plmr_pkg::DW-1:0] cfg_r [plmr_pkg::NVM_WORDS];
    logic [plmr_pkg::CNTW-1:0] ld_cnt_r;
    logic [plmr_pkg::CNTW-1:0] st_cnt_r;
    logic hard_req_r, soft_req_r;
    logic [plmr_pkg::BWW-1:0] bwn_act_r, bwf_act_r;
    logic [plmr_pkg::DW-1:0] plan_act_r;
    logic fast_act_r, auto_act_r;
    logic [plmr_pkg::SELW-1:0] man_sel_act_r;
    logic [plmr_pkg::NIN-1:0] los_r, oof_r;
    logic lol_sticky_r, lol_r, oen_r;
    logic [plmr_pkg::DW-1:0] rdata_r;
    logic [plmr_pkg::SECW-1:0] sec_cnt_r;
    logic [plmr_pkg::DW-1:0] hist_age_r;
    logic [plmr_pkg::BWW-1:0] bw_r;

    // any hard reset source puts the whole block back to power-up state
    wire hrst = !rstn || !hard_reset_pin_n || hard_req_r;
    wire in_init = (mode_r == plmr_pkg::M_INIT);
    wire bus_ok = !in_init;
    wire wr_ok = reg_wr && bus_ok;
    wire rd_ok = reg_rd && bus_ok;
    wire wr_ctrl = wr_ok && (reg_addr == plmr_pkg::A_CTRL);
    wire wr_flag = wr_ok && (reg_addr == plmr_pkg::A_FLAG);
    wire wr_lols = wr_ok && (reg_addr == plmr_pkg::A_LOLS);
    wire wr_cmd = wr_ok && (reg_addr == plmr_pkg::A_CMD);
    wire storing = (st_cnt_r != '0);
    wire ld_cap = in_init && (ld_cnt_r != '0);
    wire ld_done = in_init && (ld_cnt_r == plmr_pkg::NVM_LAST);
    wire cfg_write = wr_ok && (reg_addr < plmr_pkg::A_STAT) && !storing;
    wire [plmr_pkg::NVM_AW-1:0] ld_idx = plmr_pkg::NVM_AW'(ld_cnt_r - 3'h1);
    wire [plmr_pkg::NVM_AW-1:0] st_idx = plmr_pkg::NVM_AW'(st_cnt_r - 3'h1);

    // input selection, manual or automatic on applied settings
    wire any_valid = |in_clk_valid;
    wire [plmr_pkg::SELW-1:0] sel_w = auto_act_r ? pick_valid(in_clk_valid) : man_sel_act_r;
    wire sel_valid = in_clk_valid[sel_w];
    wire hist_valid = (hist_age_r != '0);
    wire sec_tick = (sec_cnt_r == plmr_pkg::SECW'(CYC_PER_S - 1));
    // lost input with nowhere to go: holdover if history exists, else freeze
    wire plmr_pkg::plmr_mode_type fail_mode = hist_valid ? plmr_pkg::M_HOLD : plmr_pkg::M_FRZ;

    // mode sequencer
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            plmr_pkg::M_INIT:
                if (ld_done)
                    mode_nxt = plmr_pkg::M_FREE;
            plmr_pkg::M_FREE:
                if (any_valid)
                    mode_nxt = plmr_pkg::M_ACQ;
            plmr_pkg::M_ACQ:
                if (!any_valid)
                    mode_nxt = fail_mode;
                else if (sel_valid && loop_locked)
                    mode_nxt = plmr_pkg::M_LOCK;
            plmr_pkg::M_LOCK:
                if (!any_valid)
                    mode_nxt = fail_mode;
                else if (!sel_valid || !loop_locked)
                    mode_nxt = plmr_pkg::M_ACQ;
            plmr_pkg::M_HOLD, plmr_pkg::M_FRZ:
                if (any_valid)
                    mode_nxt = plmr_pkg::M_ACQ;
            default:
                mode_nxt = plmr_pkg::M_INIT;
        endcase
        // soft reset overrides the sequence but never the init phase
        if (soft_req_r && !in_init)
            mode_nxt = plmr_pkg::M_FREE;
    end

    // state register, edge driven, init again on any hard reset
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
            mode_r <= plmr_pkg::M_INIT;
        else
            mode_r <= mode_nxt;
    end

    // nvm load counter: address goes out, word returns one cycle later
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
            ld_cnt_r <= '0;
        else if (in_init && !ld_done)
            ld_cnt_r <= ld_cnt_r + 3'h1;
    end

    // configuration words: nvm load, then register writes
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
        begin
            for (int i = 0; i < plmr_pkg::NVM_WORDS; i++)
                cfg_r[i] <= '0;
        end
        else if (ld_cap)
            cfg_r[ld_idx] <= nvm_rdata;
        else if (cfg_write)
            cfg_r[reg_addr[plmr_pkg::NVM_AW-1:0]] <= reg_wdata;
    end

    // reset request bits self-clear; hard one clears through its own reset
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
        begin
            hard_req_r <= 1'b0;
            soft_req_r <= 1'b0;
        end
        else
        begin
            hard_req_r <= wr_ctrl && reg_wdata[plmr_pkg::C_HARD];
            soft_req_r <= wr_ctrl && reg_wdata[plmr_pkg::C_SOFT];
        end
    end

    // applied settings change only at end of load or on soft reset,
    // so a half-written configuration never reaches the loop
    wire apply = ld_done || (soft_req_r && !in_init);
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
        begin
            bwn_act_r <= '0;
            bwf_act_r <= '0;
            plan_act_r <= '0;
            fast_act_r <= 1'b0;
            auto_act_r <= 1'b0;
            man_sel_act_r <= '0;
        end
        else if (apply)
        begin
            // normal word landed two edges before load end; nvm_rdata now holds the plan word
            bwn_act_r <= bw_clamp(cfg_r[1]);
            bwf_act_r <= bw_clamp(cfg_r[2]);
            plan_act_r <= ld_done ? nvm_rdata : cfg_r[3];
            fast_act_r <= cfg_r[0][plmr_pkg::C_FAST];
            auto_act_r <= cfg_r[0][plmr_pkg::C_AUTO];
            man_sel_act_r <= cfg_r[0][plmr_pkg::C_SEL +: plmr_pkg::SELW];
        end
    end

    // store sequence writes the current configuration back to nvm
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
            st_cnt_r <= '0;
        else if (st_cnt_r == plmr_pkg::NVM_LAST)
            st_cnt_r <= '0;
        else if (storing || (wr_cmd && reg_wdata[plmr_pkg::K_STORE]))
            st_cnt_r <= st_cnt_r + 3'h1;
    end
    assign nvm_rd = in_init && !ld_done;
    assign nvm_we = storing;
    assign nvm_addr = storing ? st_idx : plmr_pkg::NVM_AW'(ld_cnt_r);
    assign nvm_wdata = storing ? cfg_r[st_idx] : '0;

    // sticky flags: a set in the clearing cycle survives
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
        begin
            los_r <= '0;
            oof_r <= '0;
            lol_sticky_r <= 1'b0;
        end
        else if (!in_init)
        begin
            los_r <= (los_r & ~(wr_flag ? reg_wdata[3:0] : 4'h0)) | ~in_clk_valid;
            oof_r <= (oof_r & ~(wr_flag ? reg_wdata[7:4] : 4'h0)) | in_off_freq;
            lol_sticky_r <= (lol_sticky_r && !(wr_lols && reg_wdata[0])) || lol_r;
        end
    end

    // history age in seconds, retained while locked, capped at 120 s
    always_ff @(posedge ref_clk)
    begin
        if (hrst || mode_r != plmr_pkg::M_LOCK || sec_tick)
            sec_cnt_r <= '0;
        else
            sec_cnt_r <= sec_cnt_r + 24'h1;
    end
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
            hist_age_r <= '0;
        else if (mode_r == plmr_pkg::M_LOCK && sec_tick && hist_age_r < plmr_pkg::HIST_MAX_S)
            hist_age_r <= hist_age_r + 8'h1;
    end

    // output-side state, all registered
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
        begin
            lol_r <= 1'b1;
            oen_r <= 1'b0;
            bw_r <= '0;
        end
        else
        begin
            lol_r <= (mode_nxt != plmr_pkg::M_LOCK);
            oen_r <= (mode_nxt != plmr_pkg::M_INIT);
            bw_r <= (mode_nxt == plmr_pkg::M_ACQ && fast_act_r) ? bwf_act_r : bwn_act_r;
        end
    end

    // register read mux; the command address reads history age, refused reads give zero
    wire [plmr_pkg::DW-1:0] stat_w = {hist_valid, storing, bus_ok, lol_r, mode_r, 1'b0};
    wire [plmr_pkg::DW-1:0] rd_mux =
        (reg_addr < plmr_pkg::A_STAT) ? cfg_r[reg_addr[plmr_pkg::NVM_AW-1:0]] :
        (reg_addr == plmr_pkg::A_STAT) ? stat_w :
        (reg_addr == plmr_pkg::A_FLAG) ? {oof_r, los_r} :
        (reg_addr == plmr_pkg::A_LOLS) ? {7'h00, lol_sticky_r} :
        hist_age_r;
    always_ff @(posedge ref_clk)
    begin
        if (hrst)
            rdata_r <= '0;
        else
            rdata_r <= rd_ok ? rd_mux : '0;
    end

    assign reg_rdata = rdata_r;
    assign init_done = bus_ok;
    assign out_clk_en = oen_r;
    // in free-run, acquisition and freeze the outputs ride the oscillator
    assign loop_from_input = (mode_r == plmr_pkg::M_LOCK);
    assign loop_mode = mode_r;
    assign loop_bw = bw_r;
    assign sel_input = sel_w;
    assign hist_store_en = (mode_r == plmr_pkg::M_LOCK);
    assign lock_loss_indicator = lol_r;
    assign input_signal_absent_flag = los_r;
    assign input_off_frequency_flag = oof_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (hrst);

    sequence load_run_s;
        in_init && ld_cnt_r == '0 ##4 ld_done;
    endsequence
    init_to_free_a: assert property (load_run_s |=> mode_r == plmr_pkg::M_FREE && !soft_req_r[*1])
        else $error("free-run not entered after load");
    // mode and enable leave init on the same edge, so no look-back is needed
    outputs_off_a: assert property (in_init |-> !out_clk_en)
        else $error("outputs active during init");
    no_early_bus_a: assert property (in_init && reg_rd |=> reg_rdata == '0)
        else $error("read answered during init");
    free_holds_a: assert property (mode_r == plmr_pkg::M_FREE && !any_valid && !soft_req_r
        |=> mode_r == plmr_pkg::M_FREE)
        else $error("free-run left without input");
    acq_start_a: assert property (mode_r == plmr_pkg::M_FREE && any_valid && !soft_req_r
        |=> mode_r == plmr_pkg::M_ACQ)
        else $error("acquisition not started");
    hold_exit_a: assert property ((mode_r == plmr_pkg::M_HOLD || mode_r == plmr_pkg::M_FRZ) && any_valid
        && !soft_req_r |=> mode_r == plmr_pkg::M_ACQ)
        else $error("holdover or freeze not left");

    // two locked cycles in a row: bandwidth must be back on the normal setting
    sequence locked_two_s;
        mode_r == plmr_pkg::M_LOCK ##1 mode_r == plmr_pkg::M_LOCK;
    endsequence
    normal_bw_a: assert property (locked_two_s |-> loop_bw == bwn_act_r)
        else $error("normal bandwidth not used when locked");

    // a store walks all four words in order, one per cycle, then stops
    sequence store_run_s;
        nvm_we && nvm_addr == 2'h0 ##1 nvm_we && nvm_addr == 2'h1
            ##1 nvm_we && nvm_addr == 2'h2 ##1 nvm_we && nvm_addr == 2'h3;
    endsequence
    store_order_a: assert property (wr_cmd && reg_wdata[plmr_pkg::K_STORE] && !storing
        |=> store_run_s ##1 !nvm_we)
        else $error("store sequence broken");
    holdover_a: assert property (mode_r == plmr_pkg::M_LOCK && !any_valid && hist_valid && !soft_req_r
        |=> mode_r == plmr_pkg::M_HOLD)
        else $error("holdover not entered");
    freeze_a: assert property (mode_r == plmr_pkg::M_LOCK && !any_valid && !hist_valid && !soft_req_r
        |=> mode_r == plmr_pkg::M_FRZ)
        else $error("freeze not entered");
    lol_pin_a: assert property (##1 lock_loss_indicator == (mode_r != plmr_pkg::M_LOCK))
        else $error("lock-loss pin disagrees with mode");
    fast_bw_a: assert property (##1 mode_r == plmr_pkg::M_ACQ && fast_act_r && $stable(fast_act_r)
        |-> loop_bw == bwf_act_r)
        else $error("fast bandwidth not used in acquisition");
    soft_free_a: assert property (soft_req_r && !in_init |=> mode_r == plmr_pkg::M_FREE)
        else $error("soft reset did not restart free-run");
    five_modes_a: assert property (!in_init |-> mode_r inside {plmr_pkg::M_FREE, plmr_pkg::M_ACQ,
        plmr_pkg::M_LOCK, plmr_pkg::M_HOLD, plmr_pkg::M_FRZ})
        else $error("illegal mode");
endmodule : plmr_ctrl

// ### design/plmr_pkg.sv
// Purpose: shared constants and types of the loop mode and reset controller
// Assumes: 10 MHz ref_clk, 8-bit register port, four reference inputs
// Notes: register map offsets are word indices on the plain register port
package plmr_pkg;
    localparam int DW = 8;
    localparam int AW = 3;
    localparam int NIN = 4;
    localparam int SELW = 2;
    localparam int BWW = 4;
    // nonvolatile image: one word per configuration register
    localparam int NVM_WORDS = 4;
    localparam int NVM_AW = 2;
    localparam int CNTW = 3;
    localparam logic [CNTW-1:0] NVM_LAST = 3'h4;
    // register map
    localparam logic [AW-1:0] A_CTRL = 3'h0;
    localparam logic [AW-1:0] A_BWN = 3'h1;
    localparam logic [AW-1:0] A_BWF = 3'h2;
    localparam logic [AW-1:0] A_PLAN = 3'h3;
    localparam logic [AW-1:0] A_STAT = 3'h4;
    localparam logic [AW-1:0] A_FLAG = 3'h5;
    localparam logic [AW-1:0] A_LOLS = 3'h6;
    localparam logic [AW-1:0] A_CMD = 3'h7;
    // control and command register fields
    localparam int C_FAST = 0;
    localparam int C_AUTO = 1;
    localparam int C_SOFT = 2;
    localparam int C_HARD = 3;
    localparam int C_SEL = 4;
    localparam int K_STORE = 0;
    // bandwidth codes: 0 is 20 Hz, BW_MAX is 4 kHz
    localparam logic [BWW-1:0] BW_MAX = 4'h9;
    // history retention
    localparam int CLK_HZ = 10_000_000;
    localparam logic [DW-1:0] HIST_MAX_S = 8'h78;
    localparam int SECW = 24;
    typedef enum logic [2:0] {
        M_INIT = 3'h0,
        M_FREE = 3'h1,
        M_ACQ = 3'h3,
        M_LOCK = 3'h2,
        M_HOLD = 3'h6,
        M_FRZ = 3'h7
    } plmr_mode_type;
endpackage : plmr_pkg

// ### test/pll_mode_and_reset_control_bench.sv
// Purpose: self-checking bench for the loop mode and reset controller
// Assumes: one second shortened to 10 cycles so history builds quickly
// Notes: expectations come from the factory image and values written here
`timescale 1ns/100ps
module pll_mode_and_reset_control_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic hard_reset_pin_n = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] in_clk_valid = 4'h0;
    logic [3:0] in_off_freq = 4'h0;
    logic loop_locked = 1'b0;
    logic [7:0] reg_rdata, nvm_wdata, nvm_rdata, rd_val;
    logic nvm_rd, nvm_we, init_done, out_clk_en, loop_from_input, hist_store_en, lock_loss_indicator;
    logic [1:0] nvm_addr, sel_input;
    logic [2:0] loop_mode;
    logic [3:0] loop_bw, input_signal_absent_flag, input_off_frequency_flag;
    int error_cnt = 0;
    int n_compared = 0;

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    plmr_ctrl #(.CYC_PER_S(10)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .hard_reset_pin_n(hard_reset_pin_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nvm_rd(nvm_rd), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .in_clk_valid(in_clk_valid), .in_off_freq(in_off_freq), .loop_locked(loop_locked),
        .init_done(init_done), .out_clk_en(out_clk_en), .loop_from_input(loop_from_input),
        .loop_mode(loop_mode), .loop_bw(loop_bw), .sel_input(sel_input), .hist_store_en(hist_store_en),
        .lock_loss_indicator(lock_loss_indicator), .input_signal_absent_flag(input_signal_absent_flag),
        .input_off_frequency_flag(input_off_frequency_flag));

    plmr_nvm_model i_nvm (.ref_clk(ref_clk), .nvm_rd(nvm_rd), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));

    task automatic test_done();
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // bus cycles: strobe held for exactly one edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : rd

    // bounded waits; running out ends the run
    task automatic wait_mode(input logic [2:0] m);
        int i;
        for (i = 0; i < 40 && loop_mode !== m; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk({5'h00, loop_mode}, {5'h00, m});
        if (loop_mode !== m)
            test_done();
    endtask : wait_mode

    task automatic wait_init(input logic v);
        int i;
        for (i = 0; i < 40 && init_done !== v; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk({7'h00, init_done}, {7'h00, v});
        if (init_done !== v)
            test_done();
    endtask : wait_init

    task automatic set_in(input logic [3:0] v, input logic lk);
        @(posedge ref_clk);
        in_clk_valid <= v;
        loop_locked <= lk;
    endtask : set_in

    task automatic t_init();
        rd(plmr_pkg::A_STAT);
        chk(rd_val, 8'h00);
        chk({7'h00, out_clk_en}, 8'h00);
        wait_init(1'b1);
        wait_mode(plmr_pkg::M_FREE);
        chk({7'h00, out_clk_en}, 8'h01);
        chk({7'h00, lock_loss_indicator}, 8'h01);
        rd(plmr_pkg::A_BWN);
        chk(rd_val, 8'h02);
        rd(plmr_pkg::A_BWF);
        chk(rd_val, 8'h07);
        rd(plmr_pkg::A_PLAN);
        chk(rd_val, 8'h5A);
    endtask : t_init

    task automatic t_lock_hold();
        set_in(4'h1, 1'b0);
        wait_mode(plmr_pkg::M_ACQ);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({4'h0, loop_bw}, 8'h07);
        chk({7'h00, loop_from_input}, 8'h00);
        set_in(4'h1, 1'b1);
        wait_mode(plmr_pkg::M_LOCK);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({4'h0, loop_bw}, 8'h02);
        chk({7'h00, loop_from_input}, 8'h01);
        chk({7'h00, lock_loss_indicator}, 8'h00);
        chk({7'h00, hist_store_en}, 8'h01);
        repeat (30) @(posedge ref_clk);
        rd(plmr_pkg::A_STAT);
        chk(rd_val, 8'hA4);
        set_in(4'h0, 1'b1);
        wait_mode(plmr_pkg::M_HOLD);
        chk({7'h00, lock_loss_indicator}, 8'h01);
        set_in(4'h1, 1'b0);
        wait_mode(plmr_pkg::M_ACQ);
        set_in(4'h0, 1'b0);
        wait_mode(plmr_pkg::M_HOLD);
    endtask : t_lock_hold

    // soft reset keeps new words and puts them in effect
    task automatic t_soft();
        wr(plmr_pkg::A_BWN, 8'h03);
        wr(plmr_pkg::A_CTRL, 8'h05);
        wait_mode(plmr_pkg::M_FREE);
        rd(plmr_pkg::A_BWN);
        chk(rd_val, 8'h03);
        set_in(4'h1, 1'b1);
        wait_mode(plmr_pkg::M_LOCK);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({4'h0, loop_bw}, 8'h03);
    endtask : t_soft

    task automatic t_store_hard();
        set_in(4'h0, 1'b0);
        wr(plmr_pkg::A_PLAN, 8'hC3);
        wr(plmr_pkg::A_CMD, 8'h01);
        repeat (6) @(posedge ref_clk);
        chk(i_nvm.mem[3], 8'hC3);
        chk(i_nvm.mem[1], 8'h03);
        wr(plmr_pkg::A_BWN, 8'h09);
        wr(plmr_pkg::A_CTRL, 8'h08);
        wait_init(1'b0);
        chk({5'h00, loop_mode}, {5'h00, plmr_pkg::M_INIT});
        chk({7'h00, out_clk_en}, 8'h00);
        wait_init(1'b1);
        rd(plmr_pkg::A_BWN);
        chk(rd_val, 8'h03);
        rd(plmr_pkg::A_PLAN);
        chk(rd_val, 8'hC3);
        repeat (5) @(posedge ref_clk);
        #1;
        chk({5'h00, loop_mode}, {5'h00, plmr_pkg::M_FREE});
    endtask : t_store_hard

    // pin reset clears history, so a lost input freezes
    task automatic t_pin_freeze();
        @(posedge ref_clk);
        hard_reset_pin_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        hard_reset_pin_n <= 1'b1;
        #1;
        chk({5'h00, loop_mode}, {5'h00, plmr_pkg::M_INIT});
        wait_init(1'b1);
        // lock briefly, then lose the input before any second of history exists
        set_in(4'h1, 1'b1);
        wait_mode(plmr_pkg::M_ACQ);
        wait_mode(plmr_pkg::M_LOCK);
        set_in(4'h0, 1'b0);
        wait_mode(plmr_pkg::M_FRZ);
    endtask : t_pin_freeze

    task automatic t_flags();
        @(posedge ref_clk);
        in_clk_valid <= 4'hF;
        in_off_freq <= 4'h2;
        repeat (2) @(posedge ref_clk);
        wr(plmr_pkg::A_FLAG, 8'hFF);
        rd(plmr_pkg::A_FLAG);
        chk(rd_val, 8'h20);
        chk({4'h0, input_signal_absent_flag}, 8'h00);
        rd(plmr_pkg::A_LOLS);
        chk(rd_val, 8'h01);
        set_in(4'h7, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({4'h0, input_signal_absent_flag}, 8'h08);
        chk({4'h0, input_off_frequency_flag}, 8'h02);
        chk({6'h00, sel_input}, 8'h00);
        // automatic selection via soft reset: lowest valid input beats manual input 0
        wr(plmr_pkg::A_CTRL, 8'h06);
        set_in(4'hC, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({6'h00, sel_input}, 8'h02);
    endtask : t_flags

    // main sequence: five cycles of reset, then each scenario
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        t_init();
        t_lock_hold();
        t_soft();
        t_store_hard();
        t_pin_freeze();
        t_flags();
        test_done();
    end
endmodule : pll_mode_and_reset_control_bench

// ### test/plmr_nvm_model.sv
// Purpose: nonvolatile image beside the controller, answering loads and taking stores
// Assumes: read word follows its address by one cycle, one stored word per cycle
// Notes: idle read data toggles so a stale word never passes for a loaded one
`timescale 1ns/100ps
module plmr_nvm_model (
    input wire logic ref_clk,
    input wire logic nvm_rd,
    input wire logic nvm_we,
    input wire logic [plmr_pkg::NVM_AW-1:0] nvm_addr,
    input wire logic [plmr_pkg::DW-1:0] nvm_wdata,
    output logic [plmr_pkg::DW-1:0] nvm_rdata
);
    logic [plmr_pkg::DW-1:0] mem [plmr_pkg::NVM_WORDS];

    // factory image: fastlock on, input 0, normal bw 2, fast bw 7
    initial
    begin
        mem[0] = 8'h01;
        mem[1] = 8'h02;
        mem[2] = 8'h07;
        mem[3] = 8'h5A;
        nvm_rdata = 8'h00;
    end

    // load answer one cycle late; stores land on the same edge
    always @(posedge ref_clk)
    begin
        if (nvm_rd)
            nvm_rdata <= mem[nvm_addr];
        else
            nvm_rdata <= ~nvm_rdata;
        if (nvm_we)
            mem[nvm_addr] <= nvm_wdata;
    end
endmodule : plmr_nvm_model
